// ==== logic/mode_fault_supervisor.sv ====
// Mode and fault supervisor: sleep, normal, fail-safe and fault modes, serial
// watchdog, fault flags with clear on read, latching and delatching.
// Assumes pins and the serial link are asynchronous to clock; the auto-retry
// counter sits outside on the same clock and reports turn-on events here.
`timescale 1ns/1ns
`default_nettype none

module mode_fault_supervisor #(
	parameter int unsigned WD_CYCLES   = mode_fault_supervisor_pkg::WD_TIMEOUT_CYCLES,
	parameter int unsigned IDLE_CYCLES = mode_fault_supervisor_pkg::IN_IDLE_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link, receive only
	input  wire logic        spiClk,
	input  wire logic        spiSelect_b,
	input  wire logic        spiData,
	// Device pins
	input  wire logic        reset_pin_active_low,
	input  wire logic [1:0]  directIn,
	input  wire logic        vddPresent,
	// Fault detectors
	input  wire logic [1:0]  overcurrent_fault,
	input  wire logic [1:0]  short_circuit_fault,
	input  wire logic [1:0]  overtemperature_fault,
	input  wire logic [1:0]  shortToSupply,
	input  wire logic [1:0]  openLoadOff,
	input  wire logic [1:0]  openLoadOn,
	input  wire logic        undervoltage_fault,
	input  wire logic        overvoltage_fault,
	input  wire logic        extClockFail,
	// Auto-retry counter, same clock
	input  wire logic [1:0]  retryTurnOn,
	input  wire logic [1:0]  retriesExhausted,
	input  wire logic [1:0]  retryCounterCleared,
	output logic             retryCounterReset,
	// Outputs
	output logic      [1:0]  channelOn,
	output logic             failsafe_output_pin,
	output logic             fault_status_pin,
	output logic      [1:0]  mode
);

	localparam int unsigned SYNC_W = 22;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] syncMeta_r;
	logic [SYNC_W-1:0] syncPin_r;
	logic              rstPinS;
	logic [1:0]        inS;
	logic              vddS;
	logic              sclkS;
	logic              selS_b;
	logic              mosiS;
	logic [1:0]        ocS;
	logic [1:0]        scS;
	logic [1:0]        otS;
	logic [1:0]        osS;
	logic [1:0]        olOffS;
	logic [1:0]        olOnS;
	logic              uvS;
	logic              ovS;
	logic              clkFailS;

	// Two flip-flops on every asynchronous input
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			syncMeta_r <= '0;
			syncPin_r  <= '0;
		end
		else
		begin
			syncMeta_r <= {reset_pin_active_low, directIn, vddPresent, spiClk, spiSelect_b,
				spiData, overcurrent_fault, short_circuit_fault, overtemperature_fault,
				shortToSupply, openLoadOff, openLoadOn, undervoltage_fault,
				overvoltage_fault, extClockFail};
			syncPin_r  <= syncMeta_r;
		end
	end

	assign {rstPinS, inS, vddS, sclkS, selS_b, mosiS, ocS, scS, otS, osS, olOffS, olOnS,
		uvS, ovS, clkFailS} = syncPin_r;

	// ----------------------------------------------------------------
	// Edge detection and direct input activity
	// ----------------------------------------------------------------
	logic        sclkPrev_r;
	logic        selPrev_r;
	logic        rstPinPrev_r;
	logic [1:0]  inOn_r;
	logic [31:0] idleCount_r [2];
	logic        wake;
	logic        sleep;

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			sclkPrev_r   <= 1'b0;
			selPrev_r    <= 1'b1;
			rstPinPrev_r <= 1'b0;
		end
		else
		begin
			sclkPrev_r   <= sclkS;
			selPrev_r    <= selS_b;
			rstPinPrev_r <= rstPinS;
		end
	end

	// Activity flag rises with the input, drops after the idle timeout
	always_ff @(posedge clock)
	begin
		for (int ch = 0; ch < 2; ch++)
		begin
			if (!rst_b)
			begin
				inOn_r[ch]      <= 1'b0;
				idleCount_r[ch] <= '0;
			end
			else if (inS[ch])
			begin
				inOn_r[ch]      <= 1'b1;
				idleCount_r[ch] <= '0;
			end
			else if (idleCount_r[ch] >= IDLE_CYCLES - 1)
				inOn_r[ch]      <= 1'b0;
			else
				idleCount_r[ch] <= idleCount_r[ch] + 32'h0000_0001;
		end
	end

	assign wake  = rstPinS | inOn_r[0] | inOn_r[1];
	assign sleep = !wake;

	// ----------------------------------------------------------------
	// Serial word receiver, MSB first
	// ----------------------------------------------------------------
	logic [15:0] shift_r;
	logic [4:0]  bitCount_r;
	logic        wordDone;

	always_ff @(posedge clock)
	begin
		if (!rst_b || sleep)
		begin
			shift_r    <= '0;
			bitCount_r <= '0;
		end
		else if (!selS_b)
		begin
			if (sclkS && !sclkPrev_r)
			begin
				shift_r <= {shift_r[14:0], mosiS};
				if (bitCount_r != 5'h1F)
					bitCount_r <= bitCount_r + 5'h01;
			end
		end
		else
			bitCount_r <= '0;
	end

	// Only whole 16-bit frames count
	assign wordDone = selS_b && !selPrev_r && !sleep &&
		(bitCount_r == mode_fault_supervisor_pkg::SPI_WORD_COUNT);

	// ----------------------------------------------------------------
	// Watchdog and fail-safe state
	// ----------------------------------------------------------------
	logic                             wdArmed_r;
	logic                             lastToggle_r;
	logic [31:0]                      wdCount_r;
	logic                             wdTimeout;
	logic                             vddSeen_r;
	logic                             failsafe_r;
	logic                             fsEnter;
	logic                             fsLeave;
	logic                             faultNow;
	mode_fault_supervisor_pkg::exit_t exitState_r;
	logic [31:0]                      exitCount_r;
	logic [mode_fault_supervisor_pkg::CTRL_W-1:0] ctrl_r;

	// Armed by a rising reset pin while the logic supply is present
	always_ff @(posedge clock)
	begin
		if (!rst_b || sleep)
			wdArmed_r <= 1'b0;
		else if (rstPinS && !rstPinPrev_r && vddS)
			wdArmed_r <= 1'b1;
	end

	// Counter restarts whenever the toggle bit of a word changes
	always_ff @(posedge clock)
	begin
		if (!rst_b || sleep)
		begin
			lastToggle_r <= 1'b0;
			wdCount_r    <= '0;
		end
		else
		begin
			if (wordDone)
				lastToggle_r <= shift_r[15];
			if (!wdArmed_r || failsafe_r || (wordDone && shift_r[15] != lastToggle_r))
				wdCount_r <= '0;
			else if (wdCount_r < WD_CYCLES)
				wdCount_r <= wdCount_r + 32'h0000_0001;
		end
	end

	assign wdTimeout = wdArmed_r && (wdCount_r >= WD_CYCLES);

	// Remembers that the logic supply was once present
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			vddSeen_r <= 1'b0;
		else if (vddS)
			vddSeen_r <= 1'b1;
	end

	assign fsEnter = !failsafe_r && wake && !faultNow &&
		((vddSeen_r && !vddS && ctrl_r[mode_fault_supervisor_pkg::CTRL_VDD_FAILEN]) ||
		(wdTimeout && !ctrl_r[mode_fault_supervisor_pkg::CTRL_WATCHDOG_DISABLE_BIT]));

	// Exit needs a word with D15 set, then a second one in time
	always_ff @(posedge clock)
	begin
		if (!rst_b || !failsafe_r || faultNow)
		begin
			exitState_r <= mode_fault_supervisor_pkg::EXIT_IDLE;
			exitCount_r <= '0;
		end
		else
		begin
			case (exitState_r)
				mode_fault_supervisor_pkg::EXIT_IDLE:
				begin
					exitCount_r <= '0;
					if (wordDone && shift_r[15])
						exitState_r <= mode_fault_supervisor_pkg::EXIT_WAIT;
				end
				mode_fault_supervisor_pkg::EXIT_WAIT:
				begin
					if (wordDone || exitCount_r >= WD_CYCLES - 1)
						exitState_r <= mode_fault_supervisor_pkg::EXIT_IDLE;
					exitCount_r <= exitCount_r + 32'h0000_0001;
				end
				default:
					exitState_r <= mode_fault_supervisor_pkg::EXIT_IDLE;
			endcase
		end
	end

	assign fsLeave = failsafe_r && !faultNow && wordDone &&
		(exitState_r == mode_fault_supervisor_pkg::EXIT_WAIT) &&
		(exitCount_r < WD_CYCLES);

	// Fail-safe flag survives a fault raised inside it
	always_ff @(posedge clock)
	begin
		if (!rst_b || sleep)
			failsafe_r <= 1'b0;
		else if (fsEnter)
			failsafe_r <= 1'b1;
		else if (fsLeave)
			failsafe_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Fault detection, latching and delatching per channel
	// ----------------------------------------------------------------
	logic [1:0]      latchCause;
	logic [1:0]      offCause;
	logic [1:0]      fc;
	logic [1:0]      fcPrev_r;
	logic [1:0]      delatch;
	logic [1:0]      pending_r;
	logic [1:0]      latched_r;
	logic [1:0][5:0] cause;
	logic [1:0][5:0] faultBits_r;
	logic [1:0][8:0] duty_r;
	logic [1:0]      readFault;
	logic            readStatus;
	logic            ovOn;
	logic            clkFailOn;

	assign ovOn      = ovS && ctrl_r[mode_fault_supervisor_pkg::CTRL_OV_EN];
	assign clkFailOn = clkFailS && ctrl_r[mode_fault_supervisor_pkg::CTRL_CLKF_EN];

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		assign cause[ch]      = {olOnS[ch] & ctrl_r[mode_fault_supervisor_pkg::CTRL_OLON_EN],
			olOffS[ch] & ctrl_r[mode_fault_supervisor_pkg::CTRL_OLOFF_EN],
			osS[ch] & ctrl_r[mode_fault_supervisor_pkg::CTRL_OS_EN],
			otS[ch], scS[ch], ocS[ch]};
		assign latchCause[ch] = ocS[ch] | scS[ch] | otS[ch] | uvS;
		assign offCause[ch]   = latchCause[ch] | ovOn;
		assign fc[ch]         = (inOn_r[ch] &
			!ctrl_r[mode_fault_supervisor_pkg::CTRL_DIRDIS_LSB + ch]) |
			duty_r[ch][mode_fault_supervisor_pkg::DUTY_ON_BIT];
		assign delatch[ch]    = !latchCause[ch] && ((fc[ch] && !fcPrev_r[ch]) ||
			(retryCounterCleared[ch] &&
			ctrl_r[mode_fault_supervisor_pkg::CTRL_RETRY_EN]));
	end

	assign faultNow = |cause || uvS || ovOn || clkFailOn;

	// Pending holds a retry wait, latched holds the channel off until a delatch or fail-safe entry
	always_ff @(posedge clock)
	begin
		for (int ch = 0; ch < 2; ch++)
		begin
			if (!rst_b)
			begin
				fcPrev_r[ch]  <= 1'b0;
				pending_r[ch] <= 1'b0;
				latched_r[ch] <= 1'b0;
			end
			else
			begin
				fcPrev_r[ch] <= fc[ch];
				if (fsEnter || delatch[ch])
				begin
					pending_r[ch] <= 1'b0;
					latched_r[ch] <= 1'b0;
				end
				else if (latchCause[ch])
				begin
					pending_r[ch] <= 1'b1;
					if (retryTurnOn[ch] && retriesExhausted[ch])
						latched_r[ch] <= 1'b1;
				end
				else if (retryTurnOn[ch])
					pending_r[ch] <= 1'b0;
			end
		end
	end

	// Sticky fault bits; a new event wins over the clearing read
	always_ff @(posedge clock)
	begin
		for (int ch = 0; ch < 2; ch++)
		begin
			for (int b = 0; b < 6; b++)
			begin
				if (!rst_b || sleep || fsEnter)
					faultBits_r[ch][b] <= 1'b0;
				else if (cause[ch][b])
					faultBits_r[ch][b] <= 1'b1;
				else if (fsLeave && !latched_r[ch])
					faultBits_r[ch][b] <= 1'b0;
				else if (readFault[ch] && !latched_r[ch] && (b > 2 || !pending_r[ch]))
					faultBits_r[ch][b] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic        access;
	logic        blocked;
	logic        mapped;
	logic        writeOk;
	logic [31:0] readMux;
	logic        por_r;
	logic [2:0]  supplyBits_r;

	assign access  = psel && penable;
	assign blocked = sleep || failsafe_r;
	assign mapped  = paddr == mode_fault_supervisor_pkg::CTRL_OFFSET ||
		paddr == mode_fault_supervisor_pkg::STATUS_OFFSET ||
		paddr == mode_fault_supervisor_pkg::FAULT0_OFFSET ||
		paddr == mode_fault_supervisor_pkg::FAULT1_OFFSET ||
		paddr == mode_fault_supervisor_pkg::DUTY0_OFFSET ||
		paddr == mode_fault_supervisor_pkg::DUTY1_OFFSET;
	assign writeOk = access && pwrite && mapped && !blocked;
	assign readFault[0] = access && !pwrite && !blocked &&
		paddr == mode_fault_supervisor_pkg::FAULT0_OFFSET;
	assign readFault[1] = access && !pwrite && !blocked &&
		paddr == mode_fault_supervisor_pkg::FAULT1_OFFSET;
	assign readStatus   = access && !pwrite && !blocked &&
		paddr == mode_fault_supervisor_pkg::STATUS_OFFSET;
	assign pready  = 1'b1;
	assign pslverr = access && (!mapped || blocked);

	// Control and duty registers, held at default while asleep or in fail-safe, where the parallel bit is kept
	always_ff @(posedge clock)
	begin
		if (!rst_b || sleep)
		begin
			ctrl_r <= mode_fault_supervisor_pkg::CTRL_RESET;
			duty_r <= {2{mode_fault_supervisor_pkg::DUTY_RESET}};
		end
		else if (failsafe_r || fsEnter || fsLeave)
		begin
			ctrl_r <= mode_fault_supervisor_pkg::CTRL_RESET |
				(ctrl_r & (11'h001 << mode_fault_supervisor_pkg::CTRL_PARALLEL));
			duty_r <= {2{mode_fault_supervisor_pkg::DUTY_RESET}};
		end
		else if (writeOk)
		begin
			if (paddr == mode_fault_supervisor_pkg::CTRL_OFFSET)
				ctrl_r <= pwdata[mode_fault_supervisor_pkg::CTRL_W-1:0];
			if (paddr == mode_fault_supervisor_pkg::DUTY0_OFFSET)
				duty_r[0] <= pwdata[8:0];
			if (paddr == mode_fault_supervisor_pkg::DUTY1_OFFSET)
				duty_r[1] <= pwdata[8:0];
		end
	end

	// Power-on flag and sticky supply fault bits in the global status
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			por_r        <= 1'b1;
			supplyBits_r <= '0;
		end
		else
		begin
			if (readStatus)
				por_r <= 1'b0;
			if (sleep || fsEnter)
				supplyBits_r <= '0;
			else
				supplyBits_r <= {clkFailOn, ovOn, uvS} |
					(supplyBits_r & ~({3{readStatus}} & ~{clkFailOn, ovOn,
					uvS | (|pending_r) | (|latched_r)}));
		end
	end

	// Read data is taken in the setup phase and held through access
	always_comb
	begin
		readMux = 32'h0000_0000;
		case (paddr)
			mode_fault_supervisor_pkg::CTRL_OFFSET:   readMux[10:0] = ctrl_r;
			mode_fault_supervisor_pkg::STATUS_OFFSET: readMux[10:0] = {supplyBits_r, por_r,
				wdArmed_r, latched_r, faultNow, failsafe_r, mode};
			mode_fault_supervisor_pkg::FAULT0_OFFSET: readMux[5:0]  = faultBits_r[0];
			mode_fault_supervisor_pkg::FAULT1_OFFSET: readMux[5:0]  = faultBits_r[1];
			mode_fault_supervisor_pkg::DUTY0_OFFSET:  readMux[8:0]  = duty_r[0];
			mode_fault_supervisor_pkg::DUTY1_OFFSET:  readMux[8:0]  = duty_r[1];
			default:                                  readMux       = 32'h0000_0000;
		endcase
		if (blocked)
			readMux = 32'h0000_0000;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= readMux;
	end

	// ----------------------------------------------------------------
	// Mode, channel and pin outputs
	// ----------------------------------------------------------------
	logic [1:0] hson;

	// Fault outranks fail-safe; normal only with everything clear
	always_comb
	begin
		if (sleep)
			mode = mode_fault_supervisor_pkg::MODE_SLEEP;
		else if (faultNow)
			mode = mode_fault_supervisor_pkg::MODE_FAULT;
		else if (failsafe_r)
			mode = mode_fault_supervisor_pkg::MODE_FAILSAFE;
		else
			mode = mode_fault_supervisor_pkg::MODE_NORMAL;
	end

	// Fail-safe ignores the register bits and follows the pins
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_hson
		assign hson[ch] = failsafe_r ? inS[ch] :
			((inS[ch] & !ctrl_r[mode_fault_supervisor_pkg::CTRL_DIRDIS_LSB + ch]) |
			duty_r[ch][mode_fault_supervisor_pkg::DUTY_ON_BIT]);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			channelOn           <= 2'b00;
			failsafe_output_pin <= 1'b1;
			fault_status_pin    <= 1'b1;
			retryCounterReset   <= 1'b0;
		end
		else
		begin
			channelOn           <= sleep ? 2'b00 :
				hson & ~offCause & ~pending_r & ~latched_r;
			failsafe_output_pin <= !failsafe_r;
			fault_status_pin    <= !(faultNow || (|latched_r));
			retryCounterReset   <= fsEnter;
		end
	end

endmodule : mode_fault_supervisor

`default_nettype wire

// ==== logic/mode_fault_supervisor_pkg.sv ====
// Constants for the operating-mode and fault supervisor of a dual high-side switch.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
`default_nettype none

package mode_fault_supervisor_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLOCK_HZ          = 20_000_000;
	localparam int unsigned WD_TIMEOUT_MS     = 310;   // watchdog_timeout
	localparam int unsigned IN_IDLE_MS        = 250;   // direct input idle timeout
	localparam int unsigned WD_TIMEOUT_CYCLES = WD_TIMEOUT_MS * (CLOCK_HZ / 1000);
	localparam int unsigned IN_IDLE_CYCLES    = IN_IDLE_MS * (CLOCK_HZ / 1000);

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFFSET     = 12'h000;
	localparam logic [11:0] STATUS_OFFSET   = 12'h004; // global_status_reg
	localparam logic [11:0] FAULT0_OFFSET   = 12'h008; // channel_fault_reg, channel 0
	localparam logic [11:0] FAULT1_OFFSET   = 12'h00C; // channel_fault_reg, channel 1
	localparam logic [11:0] DUTY0_OFFSET    = 12'h010; // duty_setting_reg, channel 0
	localparam logic [11:0] DUTY1_OFFSET    = 12'h014; // duty_setting_reg, channel 1

	// ----------------------------------------------------------------
	// Control register fields and reset value
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_WATCHDOG_DISABLE_BIT     = 0;  // watchdog_disable_bit
	localparam int unsigned CTRL_VDD_FAILEN = 1;
	localparam int unsigned CTRL_DIRDIS_LSB = 2;  // two bits, one per channel
	localparam int unsigned CTRL_RETRY_EN   = 4;
	localparam int unsigned CTRL_OS_EN      = 5;
	localparam int unsigned CTRL_OLOFF_EN   = 6;
	localparam int unsigned CTRL_OLON_EN    = 7;
	localparam int unsigned CTRL_CLKF_EN    = 8;
	localparam int unsigned CTRL_OV_EN      = 9;
	localparam int unsigned CTRL_PARALLEL   = 10;
	localparam int unsigned CTRL_W          = 11;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h310;

	// Duty register: duty in 7..0, channel ON bit at 8
	localparam int unsigned DUTY_ON_BIT     = 8;
	localparam logic [8:0]  DUTY_RESET      = 9'h000;

	// Channel fault register fields
	localparam int unsigned FLT_OC          = 0;
	localparam int unsigned FLT_SC          = 1;
	localparam int unsigned FLT_OT          = 2;
	localparam int unsigned FLT_OS          = 3;
	localparam int unsigned FLT_OLOFF       = 4;
	localparam int unsigned FLT_OLON        = 5;

	// Status register fields
	localparam int unsigned ST_MODE_LSB     = 0;
	localparam int unsigned ST_FAILSAFE     = 2;
	localparam int unsigned ST_FAULT        = 3;
	localparam int unsigned ST_LATCH_LSB    = 4;
	localparam int unsigned ST_WD_ARMED     = 6;
	localparam int unsigned ST_POR          = 7;
	localparam int unsigned ST_UV           = 8;
	localparam int unsigned ST_OV           = 9;
	localparam int unsigned ST_CLKF         = 10;

	// Serial word layout
	localparam int unsigned SPI_WORD_BITS   = 16;
	localparam logic [4:0]  SPI_WORD_COUNT  = 5'h10;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_SLEEP    = 2'b00,
		MODE_NORMAL   = 2'b01,
		MODE_FAILSAFE = 2'b10,
		MODE_FAULT    = 2'b11
	} mode_t;

	// Fail-safe exit sequence
	typedef enum logic {
		EXIT_IDLE = 1'b0,
		EXIT_WAIT = 1'b1
	} exit_t;

endpackage : mode_fault_supervisor_pkg

`default_nettype wire

// ==== sim/mode_fault_supervisor_assertions.sv ====
// Port checks for the mode and fault supervisor.
// Assumes the bind below; one clock, synchronous low reset.
`timescale 1ns/1ns
`default_nettype none
module mode_fault_supervisor_assertions (
	// Watched ports
	input wire logic       clock, rst_b, psel, penable, pslverr, reset_pin_active_low,
	input wire logic       undervoltage_fault, retryCounterReset,
	input wire logic       failsafe_output_pin, fault_status_pin,
	input wire logic [1:0] overcurrent_fault, channelOn, mode
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// ------------------------------------------------
	// Mode codes: 0 sleep, 1 normal, 2 fail-safe
	// ------------------------------------------------
	sequence s_fsEntry;
		(mode == 2'h1) ##1 (mode == 2'h2);
	endsequence
	property p_fsRetry; s_fsEntry |-> ##[0:1] retryCounterReset; endproperty
	a_fsRetry: assert property (p_fsRetry) else $error("no retry reset");
	property p_sleepOff; (mode == 2'h0) [*3] |-> channelOn == 2'h0; endproperty
	a_sleepOff: assert property (p_sleepOff) else $error("on in sleep");
	property p_wake; reset_pin_active_low [*5] |-> mode != 2'h0; endproperty
	a_wake: assert property (p_wake) else $error("asleep while awake");
	property p_fsLow; (mode == 2'h2) [*3] |-> !failsafe_output_pin; endproperty
	a_fsLow: assert property (p_fsLow) else $error("pin high in fail-safe");
	property p_fsHigh; (mode == 2'h1) [*3] |-> failsafe_output_pin; endproperty
	a_fsHigh: assert property (p_fsHigh) else $error("pin low in normal");
	property p_block; psel && penable && mode[0] == 1'b0 |-> pslverr; endproperty
	a_block: assert property (p_block) else $error("access not refused");
	property p_fltPin; overcurrent_fault[0] [*6] |-> !fault_status_pin; endproperty
	a_fltPin: assert property (p_fltPin) else $error("fault pin high");
	property p_uvOff; undervoltage_fault [*6] |-> channelOn == 2'h0; endproperty
	a_uvOff: assert property (p_uvOff) else $error("on in undervoltage");
endmodule : mode_fault_supervisor_assertions
bind mode_fault_supervisor mode_fault_supervisor_assertions chk (.*);
`default_nettype wire

// ==== sim/mode_fault_supervisor_test.sv ====
// Self-checking bench for the mode and fault supervisor.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module mode_fault_supervisor_test;
	typedef struct {logic [31:0] d; logic e;} exp_t;
	logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic spiClk, spiSelect_b, spiData, reset_pin_active_low = 0, vddPresent = 1;
	logic undervoltage_fault = 0, overvoltage_fault = 0, extClockFail = 0, retryCounterReset;
	logic failsafe_output_pin, fault_status_pin;
	logic [1:0] directIn = 0, overcurrent_fault = 0, short_circuit_fault = 0, mode, channelOn;
	logic [1:0] overtemperature_fault = 0, shortToSupply = 0, openLoadOff = 0, openLoadOn = 0;
	logic [1:0] retryTurnOn = 0, retriesExhausted = 0, retryCounterCleared = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, seed = 32'h0000_5c69;
	int error_cnt = 0, num_checks = 0;
	exp_t q[$], nx;
	mode_fault_supervisor #(.WD_CYCLES(400), .IDLE_CYCLES(100)) dut (.*);
	spi_host_model host (.*);
	// 20 MHz clock
	always #25 clock = ~clock;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		num_checks++;
		if (got !== want)
		begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask : cmp
	// APB transfer; d is write data or expected read data
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		@(posedge clock);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		q.push_back('{d, e});
		@(posedge clock);
		penable <= 1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// Takes the oldest note mid-cycle, while the access phase stands
	always @(negedge clock)
		if (psel && penable && pready === 1'b1)
		begin
			nx = q.pop_front();
			if (!pwrite)
				cmp(prdata, nx.d);
			cmp({31'h0, pslverr}, {31'h0, nx.e});
		end
	// Main sequence
	initial
	begin
		tick(2);
		rst_b <= 1;
		apb(1'b0, 12'h000, 32'h0, 1'b1);
		cmp(32'(mode), 32'h0);
		reset_pin_active_low <= 1;
		tick(6);
		cmp(32'(mode), 32'h1);
		apb(1'b0, 12'h000, 32'h0000_0310, 1'b0);
		apb(1'b0, 12'h004, 32'h0000_00c1, 1'b0);
		apb(1'b0, 12'h004, 32'h0000_0041, 1'b0);
		apb(1'b0, 12'hffc, 32'h0, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			host.send({~i[0], seed[14:0]});
		end
		cmp(32'(mode), 32'h1);
		apb(1'b1, 12'h000, 32'h0000_0311, 1'b0);
		apb(1'b1, 12'h010, {23'h0, 1'b1, seed[7:0]}, 1'b0);
		apb(1'b0, 12'h010, {23'h0, 1'b1, seed[7:0]}, 1'b0);
		tick(6);
		cmp(32'(channelOn), 32'h1);
		extClockFail <= 1;
		tick(6);
		cmp({30'h0, fault_status_pin, channelOn[0]}, 32'h1);
		extClockFail <= 0;
		{openLoadOn, openLoadOff, shortToSupply} <= 6'h15;
		tick(6);
		cmp({31'h0, fault_status_pin}, 32'h1);
		{openLoadOn, openLoadOff, shortToSupply} <= 6'h00;
		$display("test setup done");
		for (int k = 0; k < 3; k++)
		begin
			{overtemperature_fault, short_circuit_fault, overcurrent_fault} <= 6'h01 << (2 * k);
			tick(6);
			cmp({mode, channelOn[0], fault_status_pin}, 32'hc);
			{overtemperature_fault, short_circuit_fault, overcurrent_fault} <= 6'h00;
			tick(6);
			cmp({31'h0, fault_status_pin}, 32'h1);
			apb(1'b0, 12'h008, 32'h1 << k, 1'b0);
			retryTurnOn <= 2'h1;
			@(posedge clock);
			retryTurnOn <= 2'h0;
			apb(1'b0, 12'h008, 32'h1 << k, 1'b0);
			apb(1'b0, 12'h008, 32'h0, 1'b0);
		end
		// Latch on exhausted retries, then delatch by toggling the ON bit
		overcurrent_fault <= 2'h1;
		retriesExhausted <= 2'h1;
		tick(6);
		retryTurnOn <= 2'h1;
		@(posedge clock);
		{retryTurnOn, retriesExhausted, overcurrent_fault} <= 6'h00;
		tick(6);
		cmp({30'h0, fault_status_pin, channelOn[0]}, 32'h0);
		apb(1'b0, 12'h008, 32'h1, 1'b0);
		apb(1'b1, 12'h010, 32'h0, 1'b0);
		apb(1'b1, 12'h010, {23'h0, 1'b1, seed[7:0]}, 1'b0);
		tick(6);
		cmp({30'h0, fault_status_pin, channelOn[0]}, 32'h3);
		apb(1'b0, 12'h008, 32'h1, 1'b0);
		apb(1'b0, 12'h008, 32'h0, 1'b0);
		$display("test latch done");
		directIn <= 2'h2;
		tick(6);
		cmp({31'h0, channelOn[1]}, 32'h1);
		undervoltage_fault <= 1;
		tick(6);
		cmp(32'(channelOn), 32'h0);
		undervoltage_fault <= 0;
		$display("test faults done");
		apb(1'b1, 12'h000, 32'h0000_0310, 1'b0);
		for (int t = 0; t < 450 && mode !== 2'h2; t++)
			@(posedge clock);
		tick(3);
		cmp({mode, failsafe_output_pin, channelOn}, 32'h12);
		apb(1'b0, 12'h010, 32'h0, 1'b1);
		directIn <= 2'h0;
		host.send(16'h8000);
		host.send(seed[15:0]);
		tick(6);
		cmp({mode, failsafe_output_pin}, 32'h3);
		apb(1'b0, 12'h010, 32'h0, 1'b0);
		$display("test fail-safe done");
		reset_pin_active_low <= 0;
		tick(120);
		cmp({mode, channelOn}, 32'h0);
		$display("test sleep done");
		summarize();
	end
	// Watchdog against a hang
	initial
	begin
		#400_000;
		$display("BAD %0t timeout", $time);
		error_cnt++;
		summarize();
	end
endmodule : mode_fault_supervisor_test
`default_nettype wire

// ==== sim/spi_host_model.sv ====
// Host model of the serial link: shifts out 16-bit words, D15 first.
// Assumes the supervisor oversamples the link with its own clock.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	// Serial link
	output logic spiClk, spiSelect_b, spiData
);
	// Idle link: clock still, select high
	initial {spiClk, spiSelect_b, spiData} = 3'h2;
	// One word at a 400 ns link period, toggle bit first
	task automatic send(input logic [15:0] w);
		#5 spiSelect_b = 0;
		for (int i = 15; i >= 0; i--)
		begin
			spiData = w[i];
			#200 spiClk = 1;
			#200 spiClk = 0;
		end
		#200 spiSelect_b = 1;
		spiData = ~spiData; // No stale data after release
		#400; // Select stays high between words
	endtask : send
endmodule : spi_host_model
`default_nettype wire
